// [design/stk_calendar.sv]
// Calendar advance: next BCD time and date values one second later.
`timescale 1ns/1ns
`default_nettype none
module stk_calendar (
   stk_cal_if.cal cal
);
   import stk_pkg::*;

   // BCD increment of a two-digit value.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
      return r;
   endfunction

   logic [7:0] sec, min, hr, date, mon, wday, yr;
   logic c_min, c_hr, c_day, c_mon, c_yr, leap;
   logic [7:0] last_day;
   logic [4:0] hr12;
   logic [5:0] hr24;

   // Ripple carry from seconds up to year.
   always_comb begin
      sec = cal.cur[ADDR_SEC];
      min = cal.cur[ADDR_MIN];
      hr = cal.cur[ADDR_HOUR];
      date = cal.cur[ADDR_DATE];
      mon = cal.cur[ADDR_MONTH];
      wday = cal.cur[ADDR_WEEKDAY];
      yr = cal.cur[ADDR_YEAR];
      hr12 = hr[4:0];
      hr24 = hr[5:0];
      // Seconds keep the halt bit; it is not part of the count.
      c_min = (sec[6:0] == 7'h59);
      sec[6:0] = c_min ? 7'h00 : 7'(bcd_inc({1'b0, sec[6:0]}));
      c_hr = c_min && (min[6:0] == 7'h59);
      if (c_min) begin
         min = c_hr ? 8'h00 : bcd_inc(min);
      end
      c_day = 1'b0;
      if (c_hr) begin
         if (hr[FMT12_BIT]) begin
            // 12-hour counting: 11 to 12 flips the meridiem, 12 to 01.
            if (hr12 == 5'h11) begin
               c_day = hr[MER_BIT];
               hr[MER_BIT] = ~hr[MER_BIT];
               hr[4:0] = 5'h12;
            end else if (hr12 == 5'h12) begin
               hr[4:0] = 5'h01;
            end else begin
               hr[4:0] = 5'(bcd_inc({3'b000, hr12}));
            end
         end else begin
            // 24-hour counting: bit 5 acts as the twenties digit.
            c_day = (hr24 == 6'h23);
            hr[5:0] = c_day ? 6'h00 : 6'(bcd_inc({2'b00, hr24}));
         end
      end
      // Leap years are those of the two-digit year divisible by four.
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
         (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02: last_day = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
         default: last_day = 8'h31;
      endcase
      c_mon = c_day && (date >= last_day);
      if (c_day) begin
         date = c_mon ? 8'h01 : bcd_inc(date);
         wday = (wday >= 8'h07) ? 8'h01 : bcd_inc(wday);
      end
      c_yr = c_mon && (mon >= 8'h12);
      if (c_mon) begin
         mon = c_yr ? 8'h01 : bcd_inc(mon);
      end
      if (c_yr) begin
         yr = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
      end
      cal.nxt[ADDR_SEC] = sec;
      cal.nxt[ADDR_MIN] = min;
      cal.nxt[ADDR_HOUR] = hr;
      cal.nxt[ADDR_DATE] = date;
      cal.nxt[ADDR_MONTH] = mon;
      cal.nxt[ADDR_WEEKDAY] = wday;
      cal.nxt[ADDR_YEAR] = yr;
   end
endmodule
`default_nettype wire

// [design/stk_timekeeper.sv]
// Serial BCD timekeeper: three-wire link, register file and timebase.
//
// Contract
// - Command bit 0: 0 write, 1 read.
// - Command bits 3..1 select one of eight registers.
// - Burst command moves all eight registers in order.
// - Write-lock set blocks timekeeping register writes.
// - Burst write never changes the write-lock bit.
// - Seconds bit 7 halts or restarts the timebase.
// - Hours bit 7 selects 12 or 24 hours.
// - Hours bit 5: PM flag or twenties digit.
// - Registers hold packed BCD within documented ranges.
// - Raised enable starts the serial control logic.
// - Low enable aborts transfer, releases data line.
// - Sample on rising edge, drive after falling.
// - Write takes eight bits LSB first, then ignores.
// - Read drives eight bits from next falling edge.
// - Continued clocking during read repeats the data.
// - Command and data travel LSB first.
`timescale 1ns/1ns
`default_nettype none
module stk_timekeeper #(
   parameter int unsigned TICK_DIV = stk_pkg::OSC_HZ
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic TRANSFER_ENABLE,
   input wire logic SHIFT_CLK,
   input wire logic DATA_IN,
   input wire logic CRYSTAL_IN,
   output logic DATA_OUT,
   output logic DATA_OE,
   output logic CRYSTAL_OUT
);
   import stk_pkg::*;

   // Pin synchronisers; the third stage exists only to find edges.
   logic en_s1_r, en_s2_r;
   logic ck_s1_r, ck_s2_r, ck_s3_r;
   logic dt_s1_r, dt_s2_r;
   logic xt_s1_r, xt_s2_r, xt_s3_r;
   logic sclk_rise, sclk_fall, xtal_rise;

   // Serial control state.
   stk_state_t st_r, st_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [2:0] addr_r, addr_nxt;
   logic burst_r, burst_nxt;
   logic out_r, out_nxt;
   logic oe_r, oe_nxt;
   logic wr_en;
   logic [7:0] rd_byte;

   // Register file and timebase.
   logic [7:0][7:0] tk_r, tk_nxt;
   logic [DIV_W-1:0] div_r, div_nxt;
   logic tick;
   logic xo_r, xo_nxt;
   logic halted, locked;

   stk_cal_if cal_bus ();

   stk_calendar u_cal (
      .cal(cal_bus.cal)
   );

   // Every pin except SYS_RST passes two flip-flops before any logic sees it.
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         dt_s1_r <= 1'b0;
         dt_s2_r <= 1'b0;
         xt_s1_r <= 1'b0;
         xt_s2_r <= 1'b0;
         xt_s3_r <= 1'b0;
      end else begin
         en_s1_r <= TRANSFER_ENABLE;
         en_s2_r <= en_s1_r;
         ck_s1_r <= SHIFT_CLK;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         dt_s1_r <= DATA_IN;
         dt_s2_r <= dt_s1_r;
         xt_s1_r <= CRYSTAL_IN;
         xt_s2_r <= xt_s1_r;
         xt_s3_r <= xt_s2_r;
      end
   end

   // Data and clock share the same synchroniser depth, so setup is kept.
   assign sclk_rise = ck_s2_r & ~ck_s3_r;
   assign sclk_fall = ~ck_s2_r & ck_s3_r;
   assign xtal_rise = xt_s2_r & ~xt_s3_r;

   assign halted = tk_r[ADDR_SEC][HALT_BIT];
   assign locked = tk_r[ADDR_LOCK][LOCK_BIT];
   assign rd_byte = tk_r[addr_r];

   // Timebase divider; it stays cleared while the oscillator is halted.
   always_comb begin
      div_nxt = div_r;
      tick = 1'b0;
      xo_nxt = 1'b0;
      if (halted) begin
         div_nxt = '0;
      end else begin
         xo_nxt = ~xt_s2_r;
         if (xtal_rise) begin
            if (32'(div_r) == TICK_DIV - 1) begin
               div_nxt = '0;
               tick = 1'b1;
            end else begin
               div_nxt = div_r + DIV_W'(1);
            end
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         div_r <= '0;
         xo_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         xo_r <= xo_nxt;
      end
   end

   // Serial command and data engine.
   always_comb begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      addr_nxt = addr_r;
      burst_nxt = burst_r;
      out_nxt = out_r;
      oe_nxt = oe_r;
      wr_en = 1'b0;
      if (!en_s2_r) begin
         // A low enable ends any transfer and floats the data line.
         st_nxt = ST_IDLE;
         bit_nxt = 3'h0;
         oe_nxt = 1'b0;
         out_nxt = 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               st_nxt = ST_CMD;
               bit_nxt = 3'h0;
            end
            ST_CMD: begin
               if (sclk_rise) begin
                  sh_nxt = {dt_s2_r, sh_r[7:1]};
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     burst_nxt = (sh_nxt[6:1] == BURST_SEL);
                     addr_nxt = burst_nxt ? ADDR_SEC : sh_nxt[3:1];
                     if (!sh_nxt[7] || (sh_nxt[7:4] == TEST_HIGH && sh_nxt[0])) begin
                        // Invalid and test commands are ignored outright.
                        st_nxt = ST_DONE;
                     end else if (sh_nxt[DIR_BIT]) begin
                        st_nxt = ST_RDATA;
                     end else begin
                        st_nxt = ST_WDATA;
                     end
                  end
               end
            end
            ST_WDATA: begin
               if (sclk_rise) begin
                  sh_nxt = {dt_s2_r, sh_r[7:1]};
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     wr_en = 1'b1;
                     if (burst_r && addr_r != ADDR_LOCK) begin
                        addr_nxt = addr_r + 3'h1;
                     end else begin
                        st_nxt = ST_DONE;
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (sclk_fall) begin
                  out_nxt = rd_byte[bit_r];
                  oe_nxt = 1'b1;
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7 && burst_r) begin
                     // Wraps past the last register, so bursts repeat.
                     addr_nxt = addr_r + 3'h1;
                  end
               end
            end
            ST_DONE: begin
               st_nxt = ST_DONE;
            end
            default: begin
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         st_r <= ST_IDLE;
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         addr_r <= 3'h0;
         burst_r <= 1'b0;
         out_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         addr_r <= addr_nxt;
         burst_r <= burst_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign cal_bus.cur = tk_r[6:0];

   // Register file: a host write in the same cycle as a tick wins.
   always_comb begin
      tk_nxt = tk_r;
      if (tick) begin
         tk_nxt[6:0] = cal_bus.nxt;
      end
      if (wr_en) begin
         if (addr_r == ADDR_LOCK) begin
            if (!burst_r) begin
               // Only the lock bit is stored; the other seven bits read as zero.
               tk_nxt[ADDR_LOCK] = {sh_nxt[LOCK_BIT], 7'h00};
            end
         end else if (!locked) begin
            tk_nxt[addr_r] = sh_nxt;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         tk_r[ADDR_SEC] <= RST_SEC;
         tk_r[ADDR_MIN] <= RST_MIN;
         tk_r[ADDR_HOUR] <= RST_HOUR;
         tk_r[ADDR_DATE] <= RST_DATE;
         tk_r[ADDR_MONTH] <= RST_MONTH;
         tk_r[ADDR_WEEKDAY] <= RST_WEEKDAY;
         tk_r[ADDR_YEAR] <= RST_YEAR;
         tk_r[ADDR_LOCK] <= RST_LOCK;
      end else begin
         tk_r <= tk_nxt;
      end
   end

   // Outputs come straight from flip-flops.
   assign DATA_OUT = out_r;
   assign DATA_OE = oe_r;
   assign CRYSTAL_OUT = xo_r;
endmodule
`default_nettype wire

// [include/stk_cal_if.sv]
// Carrier between the register file and the calendar advance logic.
`timescale 1ns/1ns
`default_nettype none
interface stk_cal_if;
   logic [6:0][7:0] cur;
   logic [6:0][7:0] nxt;
   modport regs (output cur, input nxt);
   modport cal (input cur, output nxt);
endinterface
`default_nettype wire

// [include/stk_pkg.sv]
// Shared constants and types for the serial BCD timekeeper.
package stk_pkg;
   // Register select codes.
   localparam logic [2:0] ADDR_SEC = 3'h0;
   localparam logic [2:0] ADDR_MIN = 3'h1;
   localparam logic [2:0] ADDR_HOUR = 3'h2;
   localparam logic [2:0] ADDR_DATE = 3'h3;
   localparam logic [2:0] ADDR_MONTH = 3'h4;
   localparam logic [2:0] ADDR_WEEKDAY = 3'h5;
   localparam logic [2:0] ADDR_YEAR = 3'h6;
   localparam logic [2:0] ADDR_LOCK = 3'h7;
   // Field positions.
   localparam int HALT_BIT = 7;
   localparam int FMT12_BIT = 7;
   localparam int MER_BIT = 5;
   localparam int LOCK_BIT = 7;
   localparam int DIR_BIT = 0;
   // Command byte fields.
   localparam logic [5:0] BURST_SEL = 6'h1f;
   localparam logic [3:0] TEST_HIGH = 4'h9;
   // Reset values: clock halted and write-locked until the host unlocks it.
   localparam logic [7:0] RST_SEC = 8'h80;
   localparam logic [7:0] RST_MIN = 8'h00;
   localparam logic [7:0] RST_HOUR = 8'h00;
   localparam logic [7:0] RST_DATE = 8'h01;
   localparam logic [7:0] RST_MONTH = 8'h01;
   localparam logic [7:0] RST_WEEKDAY = 8'h01;
   localparam logic [7:0] RST_YEAR = 8'h00;
   localparam logic [7:0] RST_LOCK = 8'h80;
   // Timebase: crystal rising edges per one-second tick.
   localparam int OSC_HZ = 32768;
   localparam int DIV_W = 16;
   // Serial control states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_WDATA = 3'b010,
      ST_RDATA = 3'b011,
      ST_DONE = 3'b100
   } stk_state_t;
endpackage

// [verif/stk_host_model.sv]
// Host-side link master for the timekeeper bench.
`timescale 1ns/1ns
`default_nettype none
module stk_host_model (
   input wire logic clk,
   input wire logic dev_out,
   input wire logic dev_oe,
   output logic xfer_en = 1'b0,
   output logic sclk = 1'b0,
   output wire logic dwire
);
   logic drv = 1'b0;
   logic hoe = 1'b0;
   logic flip = 1'b0;
   // An undriven line shows a level that changes every cycle, never a held value.
   always @(posedge clk) begin
      flip <= ~flip;
   end
   assign dwire = dev_oe ? dev_out : (hoe ? drv : flip);
   // One frame: command, then nb bits, 8 + nb pulses; never a test-mode command.
   task automatic xfer(input logic [7:0] cmd, input int nb, input logic [63:0] wr,
      output logic [63:0] q);
      logic [71:0] bits;
      bits = {wr, cmd};
      q = 64'h0;
      xfer_en <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8 + nb; i++) begin
         sclk <= 1'b0;
         hoe <= (i < 8) || !cmd[0];
         drv <= bits[i];
         repeat (5) @(posedge clk);
         sclk <= 1'b1;
         @(posedge clk);
         if (i >= 8) begin
            q[i - 8] = dwire;
         end
         repeat (2) @(posedge clk);
      end
      sclk <= 1'b0;
      hoe <= 1'b0;
      xfer_en <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [verif/stk_timekeeper_properties.sv]
// Link and crystal pin checks for the timekeeper.
`timescale 1ns/1ns
`default_nettype none
module stk_timekeeper_properties (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic TRANSFER_ENABLE,
   input wire logic SHIFT_CLK,
   input wire logic DATA_IN,
   input wire logic CRYSTAL_IN,
   input wire logic DATA_OUT,
   input wire logic DATA_OE,
   input wire logic CRYSTAL_OUT
);
   logic sclk_q_r;
   logic rd_cmd_r;
   logic rd_cmd_nxt;
   logic [6:0] rises_r;
   logic [6:0] rises_nxt;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // Rises per frame, saturated so a long read cannot wrap; bit 0 of the command kept.
   always_comb begin
      rises_nxt = rises_r;
      rd_cmd_nxt = rd_cmd_r;
      if (SYS_RST || !TRANSFER_ENABLE) begin
         rises_nxt = 7'h00;
      end else if (SHIFT_CLK && !sclk_q_r && rises_r != 7'h7F) begin
         rises_nxt = rises_r + 7'h01;
         if (rises_r == 7'h00) begin
            rd_cmd_nxt = DATA_IN;
         end
      end
   end
   // Registers the helper state.
   always_ff @(posedge REF_CLK) begin
      sclk_q_r <= SHIFT_CLK;
      rises_r <= rises_nxt;
      rd_cmd_r <= SYS_RST ? 1'b0 : rd_cmd_nxt;
   end
   AST_OE_RELEASE: assert property ($fell(TRANSFER_ENABLE) |-> ##[1:4] !DATA_OE)
      else $error("data line driven after enable fell");
   AST_OE_NEEDS_EN: assert property (DATA_OE |-> $past(TRANSFER_ENABLE, 4))
      else $error("data line driven without enable");
   AST_FIRST_BIT: assert property ($rose(DATA_OE) |-> rises_r == 7'h08)
      else $error("first read bit not after command");
   AST_NO_EARLY_OE: assert property (TRANSFER_ENABLE && rises_r < 7'h08 |-> !DATA_OE)
      else $error("data line driven during command");
   AST_DRIVE_AFTER_FALL: assert property ($rose(DATA_OE) |-> !$past(SHIFT_CLK, 3))
      else $error("drive began off a falling edge");
   AST_BIT_ON_FALL: assert property (
      DATA_OE && $past(DATA_OE) && $changed(DATA_OUT) |-> !$past(SHIFT_CLK, 3))
      else $error("read bit changed off a falling edge");
   AST_OE_HOLDS: assert property (DATA_OE && TRANSFER_ENABLE ##1 TRANSFER_ENABLE |-> DATA_OE)
      else $error("read went silent while enabled");
   AST_WRITE_QUIET: assert property (!rd_cmd_r |-> !DATA_OE)
      else $error("data line driven in a write frame");
   AST_XTAL_FOLLOW: assert property ($rose(CRYSTAL_OUT) |-> !$past(CRYSTAL_IN, 3))
      else $error("crystal output not inverted input");
   cover property ($rose(DATA_OE));
   cover property (rises_r == 7'h48);
   cover property ($rose(CRYSTAL_OUT));
endmodule
bind stk_timekeeper stk_timekeeper_properties stk_timekeeper_properties_inst (
   .REF_CLK, .SYS_RST, .TRANSFER_ENABLE, .SHIFT_CLK, .DATA_IN, .CRYSTAL_IN, .DATA_OUT,
   .DATA_OE, .CRYSTAL_OUT);
`default_nettype wire

// [verif/stk_timekeeper_tb_top.sv]
// Self-checking bench for the serial timekeeper.
`timescale 1ns/1ns
`default_nettype none
module stk_timekeeper_tb_top;
   import stk_pkg::*;
   typedef struct {
      logic [2:0] adr;
      logic [7:0] wr;
      logic [7:0] exp;
   } stk_row_t;
   localparam logic [63:0] RST_V = {RST_LOCK, RST_YEAR, RST_WEEKDAY, RST_MONTH,
      RST_DATE, RST_HOUR, RST_MIN, RST_SEC};
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic xtal = 1'b0;
   wire logic en;
   wire logic sclk;
   wire logic dwire;
   wire logic dout;
   wire logic doe;
   wire logic xout;
   int fails = 0;
   int samples_checked = 0;
   logic [63:0] rd;
   stk_row_t rows[9] = '{
      '{ADDR_SEC, 8'hC5, 8'hC5}, '{ADDR_MIN, 8'h59, 8'h59}, '{ADDR_HOUR, 8'h23, 8'h23},
      '{ADDR_HOUR, 8'hB2, 8'hB2}, '{ADDR_DATE, 8'h31, 8'h31}, '{ADDR_MONTH, 8'h12, 8'h12},
      '{ADDR_WEEKDAY, 8'h07, 8'h07}, '{ADDR_YEAR, 8'h99, 8'h99}, '{ADDR_LOCK, 8'h7F, 8'h00}};
   // A short divider keeps a simulated second at a few dozen cycles.
   stk_timekeeper #(.TICK_DIV(4)) stk_timekeeper_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
      .TRANSFER_ENABLE(en), .SHIFT_CLK(sclk), .DATA_IN(dwire), .CRYSTAL_IN(xtal),
      .DATA_OUT(dout), .DATA_OE(doe), .CRYSTAL_OUT(xout));
   stk_host_model stk_host_model_inst (.clk(ref_clk), .dev_out(dout), .dev_oe(doe),
      .xfer_en(en), .sclk(sclk), .dwire(dwire));
   // The 25 MHz system clock.
   always #20 ref_clk = ~ref_clk;
   task automatic check_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr1(input logic [2:0] a, input logic [7:0] d);
      stk_host_model_inst.xfer({4'h8, a, 1'b0}, 8, {56'h0, d}, rd);
   endtask
   task automatic rd1(input logic [2:0] a, input logic [7:0] exp);
      stk_host_model_inst.xfer({4'h8, a, 1'b1}, 8, 64'h0, rd);
      check_byte("register", exp, rd[7:0]);
   endtask
   task automatic burst_chk(input logic [63:0] exp);
      stk_host_model_inst.xfer(8'hBF, 64, 64'h0, rd);
      for (int k = 0; k < 8; k++) begin
         check_byte("burst byte", exp[8*k+:8], rd[8*k+:8]);
      end
   endtask
   // Crystal stands still except while a test lets n rising edges through.
   task automatic run_xtal(input int n);
      repeat (n) begin
         repeat (4) @(posedge ref_clk);
         xtal <= 1'b1;
         repeat (4) @(posedge ref_clk);
         xtal <= 1'b0;
      end
      repeat (12) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence: reset values, then table rows, then the awkward cases.
   initial begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      burst_chk(RST_V);
      wr1(ADDR_LOCK, 8'h00);
      foreach (rows[i]) begin
         wr1(rows[i].adr, rows[i].wr);
         rd1(rows[i].adr, rows[i].exp);
      end
      stk_host_model_inst.xfer({4'h8, ADDR_MIN, 1'b1}, 24, 64'h0, rd);
      for (int k = 0; k < 3; k++) begin
         check_byte("repeat byte", 8'h59, rd[8*k+:8]);
      end
      stk_host_model_inst.xfer(8'hBE, 64, 64'h8024_0507_1508_30A0, rd);
      burst_chk(64'h0024_0507_1508_30A0);
      stk_host_model_inst.xfer({4'h8, ADDR_MIN, 1'b0}, 4, 64'h0, rd);
      rd1(ADDR_MIN, 8'h30);
      stk_host_model_inst.xfer({4'h8, ADDR_MIN, 1'b0}, 16, 64'h1142, rd);
      rd1(ADDR_MIN, 8'h42);
      stk_host_model_inst.xfer(8'hBE, 64, 64'h0000_0102_2823_5958, rd);
      run_xtal(8);
      check_byte("crystal out", 8'h01, {7'h00, xout});
      burst_chk(64'h0000_0202_2900_0000);
      stk_host_model_inst.xfer(8'hBE, 64, 64'h0001_0102_2823_5959, rd);
      run_xtal(4);
      burst_chk(64'h0001_0203_0100_0000);
      // Twelve-hour counting: 11:59:59 PM on the last day of year 99 rolls every field.
      stk_host_model_inst.xfer(8'hBE, 64, 64'h0099_0712_31B1_5959, rd);
      run_xtal(4);
      burst_chk(64'h0000_0101_0192_0000);
      wr1(ADDR_SEC, 8'hD0);
      run_xtal(8);
      check_byte("crystal out", 8'h00, {7'h00, xout});
      rd1(ADDR_SEC, 8'hD0);
      wr1(ADDR_LOCK, 8'h80);
      wr1(ADDR_SEC, 8'h11);
      rd1(ADDR_SEC, 8'hD0);
      stk_host_model_inst.xfer({4'h0, ADDR_LOCK, 1'b0}, 8, 64'h0, rd);
      rd1(ADDR_LOCK, 8'h80);
      // A reset in mid-run must bring back the halted and locked state.
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      burst_chk(RST_V);
      tally_and_finish();
   end
   // Cuts a hang short; the sequence needs about 10600 cycles.
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
